// *** dv/isc_bus_master.sv ***
// behavioural two-wire bus master that drives the slave under test
`timescale 1ns/1ps
module isc_bus_master (
    // clock and resolved data line
    input  wire logic clk_i,
    input  wire logic sda_i,
    // open-drain levels, 1 = released
    output logic      scl_o,
    output logic      sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    // wait a number of system clocks
    task automatic w(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // one bit slot of eight clocks: five low, three high; the long low phase
    // lets the slave's synchronised answer settle before the clock rises
    task automatic bit_slot(input logic o, output logic i);
        sda_o <= o;
        w(4);
        scl_o <= 1'b1;
        w(3);
        i = sda_i;
        scl_o <= 1'b0;
        w(1);
    endtask
    // start or repeated start; slow release so a held ack is let go first
    task automatic start();
        sda_o <= 1'b1;
        w(6);
        scl_o <= 1'b1;
        w(4);
        sda_o <= 1'b0;
        w(4);
        scl_o <= 1'b0;
        w(1);
    endtask
    // stop ends the frame; both lines then stand released
    task automatic stop();
        sda_o <= 1'b0;
        w(6);
        scl_o <= 1'b1;
        w(4);
        sda_o <= 1'b1;
        w(4);
    endtask
    // send a byte msb first, return the slave's answer (1 = ack)
    task automatic wr(input logic [7:0] d, output logic ak);
        logic b;
        for (int k = 7; k >= 0; k--) begin
            bit_slot(d[k], b);
        end
        bit_slot(1'b1, b);
        ak = !b;
    endtask
    // read a byte msb first and answer it with ack or nak
    task automatic rd(input logic ak, output logic [7:0] d);
        logic b;
        for (int k = 7; k >= 0; k--) begin
            bit_slot(1'b1, d[k]);
        end
        bit_slot(!ak, b);
    endtask
endmodule

// *** dv/isc_slave_tb.sv ***
// self-checking bench for the two-wire slave with its register file
`timescale 1ns/1ps
module isc_slave_tb;
    import isc_pkg::*;
    logic        clk, nrst, cyc, stb, we, ack, irq, scl_m, sda_m;
    logic        scl_q, scl_oe, sda_q, sda_oe, scl_w, sda_w;
    logic [7:0]  adr, q, d, own;
    logic [31:0] wdat, rdat;
    logic        ak;
    int          n_fail, cmp_count, seed;
    logic [7:0]  rxq[$];  // bytes sent by the master, in order
    // wired-and open-drain lines with pull-ups
    assign scl_w = scl_m & (scl_oe ? scl_q : 1'b1);
    assign sda_w = sda_m & (sda_oe ? sda_q : 1'b1);
    ////////////////////////////////////////////////////////////////////////
    isc_slave uut (.CLK_SYS_I(clk), .NRST_I(nrst), .CE_I(1'b1), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
        .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .IRQ_O(irq),
        .SCL_I(scl_w), .SCL_O(scl_q), .SCL_OE_O(scl_oe), .SDA_I(sda_w),
        .SDA_O(sda_q), .SDA_OE_O(sda_oe));
    isc_bus_master m (.clk_i(clk), .sda_i(sda_w), .scl_o(scl_m), .sda_o(sda_m));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // compare and count
    task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // classic single wishbone cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] v);
        int n;
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, 24'h0, v};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_fail++;
            test_done();
        end
        q = rdat[7:0];
        {cyc, stb} <= 2'b00;
        @(posedge clk);
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] mk,
                         input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        chk(nm, q & mk, e);
    endtask
    task automatic irq_chk(input logic e);
        repeat (2) @(posedge clk);
        chk("irq", {7'h00, irq}, {7'h00, e});
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {nrst, cyc, stb, we, adr, wdat, n_fail, cmp_count} = '0;
        seed = 32'hF51B;
        // top address bit forced high: own and its neighbour never hit general call
        own = {2'b01, 6'($random(seed))};
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        rdchk("bstat", OFS_BSTAT, 8'hFF, RST_BSTAT);
        wb(1'b1, OFS_BSTAT, 8'($random(seed)));
        rdchk("bstat_ro", OFS_BSTAT, 8'hFF, RST_BSTAT);
        wb(1'b1, OFS_CTL, 8'h06);
        wb(1'b1, OFS_OADDR, own);
        wb(1'b1, OFS_MODE, {6'h00, MODE_SLAVE});
        rdchk("mode", OFS_MODE, 8'h03, {6'h00, MODE_SLAVE});
        // general call while masked, then unmask
        m.start();
        m.wr(8'h00, ak);
        chk("gc_ack", {7'h00, ak}, 8'h01);
        irq_chk(1'b0);
        wb(1'b1, OFS_IMASK, 8'h62);
        irq_chk(1'b1);
        rdchk("istat", OFS_ISTAT, 8'hFF, 8'hA0);
        rdchk("istat_clr", OFS_ISTAT, 8'hFF, 8'h80);
        irq_chk(1'b0);
        // repeated start to own address, two bytes, second refused
        m.start();
        m.wr({own[6:0], 1'b0}, ak);
        chk("adr_ack", {7'h00, ak}, 8'h01);
        rdchk("istat_sr", OFS_ISTAT, 8'hFF, 8'hA2);
        rdchk("bstat_sr", OFS_BSTAT, 8'h45, 8'h45);
        for (int i = 0; i < 2; i++) begin
            d = 8'($random(seed));
            rxq.push_back(d);
            if (i == 1) wb(1'b1, OFS_CTL, 8'h07);
            m.wr(d, ak);
            chk("rx_ack", {7'h00, ak}, {7'h00, i == 0});
            rdchk("istat_rx", OFS_ISTAT, 8'hFF, 8'hC0);
            rdchk("data", OFS_DATA, 8'hFF, rxq.pop_front());
            rdchk("istat_rd", OFS_ISTAT, 8'hFF, 8'h80);
        end
        wb(1'b1, OFS_CTL, 8'h06);
        m.stop();
        rdchk("istat_p", OFS_ISTAT, 8'hFF, 8'h82);
        rdchk("bstat_p", OFS_BSTAT, 8'h05, 8'h00);
        rdchk("istat_pc", OFS_ISTAT, 8'hFF, 8'h80);
        // foreign address is left alone
        m.start();
        m.wr({own[6:0] ^ 7'h01, 1'b0}, ak);
        chk("mis_ack", {7'h00, ak}, 8'h00);
        m.stop();
        rdchk("istat_mis", OFS_ISTAT, 8'hFF, 8'h80);
        // master read of one byte, answered with nak
        d = 8'($random(seed));
        wb(1'b1, OFS_DATA, d);
        m.start();
        m.wr({own[6:0], 1'b1}, ak);
        chk("rd_ack", {7'h00, ak}, 8'h01);
        rdchk("istat_rdir", OFS_ISTAT, 8'hFF, 8'h28);
        m.rd(1'b0, q);
        chk("tx_byte", q, d);
        rdchk("bstat_nak", OFS_BSTAT, 8'hC0, 8'h80);
        m.stop();
        // direction bit keeps the last address phase's value
        rdchk("istat_end", OFS_ISTAT, 8'h2A, 8'h0A);
        test_done();
    end
endmodule

// *** src/isc_pkg.sv ***
// package: register map, field positions, reset values, bit counts and engine states of the two-wire slave
package isc_pkg;
    // register byte offsets on the wishbone bus
    localparam logic [7:0] OFS_DATA   = 8'h00;  // data_reg: rx byte read, tx byte write
    localparam logic [7:0] OFS_ISTAT  = 8'h04;  // irq_status_reg
    localparam logic [7:0] OFS_IMASK  = 8'h08;  // interrupt mask, same layout
    localparam logic [7:0] OFS_CTL    = 8'h0C;  // control_reg
    localparam logic [7:0] OFS_MODE   = 8'h10;  // mode field
    localparam logic [7:0] OFS_OADDR  = 8'h14;  // own_addr
    localparam logic [7:0] OFS_BSTAT  = 8'h18;  // bus_status, read only

    // irq_status_reg field positions
    localparam int IS_TXE = 7;  // tx_empty_flag
    localparam int IS_RXF = 6;  // rx_byte_full
    localparam int IS_HIT = 5;  // slave_address_match
    localparam int IS_RD  = 3;  // direction: 1 = master reads
    localparam int IS_SPR = 1;  // stop_restart_flag

    // control_reg field positions
    localparam int CT_NAK = 0;  // refuse next byte
    localparam int CT_GCA = 1;  // general_call_enable
    localparam int CT_EN  = 2;  // slave engine enable

    // bus_status field positions
    localparam int BS_ACK_VLD = 7;  // ack_valid
    localparam int BS_ACK     = 6;
    localparam int BS_ADR_PH  = 5;  // addr_transfer_flag
    localparam int BS_DAT_PH  = 4;  // data_phase_flag
    localparam int BS_TENBIT  = 3;  // ten_bit_addr_flag
    localparam int BS_RESTART = 2;  // restart_not_stop
    localparam int BS_SCLD    = 1;  // clock_line_drive
    localparam int BS_BUSY    = 0;

    // mode field values
    localparam logic [1:0] MODE_MS    = 2'h0;  // master/slave, 7-bit
    localparam logic [1:0] MODE_SLAVE = 2'h1;  // slave only, 7-bit

    // reset values
    localparam logic [7:0] RST_CTL   = 8'h00;
    localparam logic [7:0] RST_IMASK = 8'h00;
    localparam logic [6:0] RST_OADDR = 7'h00;
    localparam logic [6:0] GC_ADDR   = 7'h00;  // general-call address
    localparam logic [7:0] RST_BSTAT = 8'h02;  // clock_line_drive reads one

    // bit counting
    localparam logic [3:0] LAST_BIT  = 4'h7;   // rise index of the eighth bit
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // engine states
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_WAIT
    } isc_state_e;
endpackage

// *** src/isc_slave.sv ***
// two-wire bus slave with 7-bit addressing and a wishbone register file
//
// Notes on behaviour
// - write address match sets flag, clears direction
// - acknowledge own address on the bus
// - status read clears address-match flag
// - ack each byte unless refuse bit set
// - received byte sets rx full flag
// - data register read clears rx full
// - stop or restart after an address match sets stop flag
// - status read clears stop flag
// - master read: address, ack, data, ack, stop
// - mode field, general call enable, own address
// - ack valid set after tx, cleared later
// - ack bit holds last byte ack result
// - restart bit: zero stop, one restart
// - busy bit high while transaction runs
`timescale 1ns/1ps
module isc_slave
    import isc_pkg::*;
(
    // clock, reset, enable
    input  wire logic        CLK_SYS_I,
    input  wire logic        NRST_I,
    input  wire logic        CE_I,
    // wishbone classic slave
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    // interrupt
    output logic             IRQ_O,
    // two-wire bus pins, open drain
    input  wire logic        SCL_I,
    output logic             SCL_O,
    output logic             SCL_OE_O,
    input  wire logic        SDA_I,
    output logic             SDA_O,
    output logic             SDA_OE_O
);
    ////////////////////////////////////////////////////////////////////////////////
    // reset release and pin synchronisers
    logic [1:0]  rst_q;      // reset release chain
    logic        rst_n;      // synchronised reset
    logic [1:0]  pin_s;      // {scl, sda} after two flops
    logic        scl_p;      // previous synchronised scl
    logic        sda_p;      // previous synchronised sda

    // release reset through two flops
    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    isc_sync #(.WIDTH(2)) u_sync (
        .clk_i   (CLK_SYS_I),
        .rst_n_i (rst_n),
        .ce_i    (CE_I),
        .async_i ({SCL_I, SDA_I}),
        .init_i  (2'h3),
        .sync_o  (pin_s)
    );

    // remember last sampled line levels for edge finding
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end else if (CE_I) begin
            scl_p <= pin_s[1];
            sda_p <= pin_s[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers and line events
    logic [7:0] ctl_q;       // control_reg
    logic [1:0] mode_q;      // mode field
    logic [6:0] own_addr_q;  // own_addr
    logic [7:0] imask_q;     // interrupt mask
    logic [7:0] tx_hold_q;   // byte to send
    logic [7:0] rx_data_q;   // last byte received
    logic       txe_q, rxf_q, addr_hit_q, spr_q, rd_q;  // status flags
    isc_state_e st_q;        // engine state
    logic [3:0] cnt_q;       // rise counter inside a byte
    logic [7:0] sh_q;        // receive shifter / transmit copy
    logic       drv_q;       // second half of an acknowledge slot
    logic       ack_q, ack_valid_q, restart_q, busy_q, addressed_q;
    logic       sda_oe_q;

    logic scl_s, sda_s, scl_rise, scl_fall, start_w, stop_w, match_w;
    logic set_hit, set_rx, set_spr, load_tx, acc, rd_stat, rd_data, wr_w;
    assign scl_s    = pin_s[1];
    assign sda_s    = pin_s[0];
    assign scl_rise = CE_I && scl_s && !scl_p;
    assign scl_fall = CE_I && !scl_s && scl_p;
    assign start_w  = CE_I && scl_s && scl_p && sda_p && !sda_s;
    assign stop_w   = CE_I && scl_s && scl_p && !sda_p && sda_s;
    // address compare against own and general call
    assign match_w  = ctl_q[CT_EN] && ((sh_q[6:0] == own_addr_q) ||
                      (ctl_q[CT_GCA] && sh_q[6:0] == GC_ADDR && !sda_s));
    assign set_hit  = scl_rise && st_q == ST_ADDR && cnt_q == LAST_BIT && match_w;
    assign set_rx   = scl_rise && st_q == ST_RX && cnt_q == LAST_BIT;
    assign set_spr  = (start_w || stop_w) && addressed_q;
    assign load_tx  = scl_fall && drv_q && ((st_q == ST_ADDR_ACK && rd_q) ||
                      (st_q == ST_TX_ACK && ack_q));
    // a bus access acts once, at the edge that raises ack
    assign acc      = CE_I && WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign wr_w     = acc && WB_WE_I && WB_SEL_I[0];
    assign rd_stat  = acc && !WB_WE_I && WB_ADR_I == OFS_ISTAT;
    assign rd_data  = acc && !WB_WE_I && WB_ADR_I == OFS_DATA;

    ////////////////////////////////////////////////////////////////////////////////
    // byte engine: addressing, receive, transmit, acknowledge slots
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            st_q     <= ST_IDLE;
            cnt_q    <= 4'h0;
            sh_q     <= 8'h00;
            drv_q    <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (start_w) begin
            // start or restart: new address phase
            st_q     <= ST_ADDR;
            cnt_q    <= 4'h0;
            drv_q    <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (stop_w) begin
            st_q     <= ST_IDLE;
            sda_oe_q <= 1'b0;
        end else begin
            case (st_q)
                ST_ADDR, ST_RX: begin
                    // sample on rising clock
                    if (scl_rise) begin
                        sh_q  <= {sh_q[6:0], sda_s};
                        cnt_q <= cnt_q + 4'h1;
                        if (cnt_q == LAST_BIT) begin
                            cnt_q <= 4'h0;
                            if (st_q == ST_RX) begin
                                st_q <= ST_RX_ACK;
                            end else begin
                                st_q <= match_w ? ST_ADDR_ACK : ST_WAIT;
                            end
                        end
                    end
                end
                ST_ADDR_ACK, ST_RX_ACK: begin
                    // first fall drives the slot, second fall releases it
                    if (scl_fall && !drv_q) begin
                        drv_q    <= 1'b1;
                        sda_oe_q <= (st_q == ST_ADDR_ACK) || !ctl_q[CT_NAK];
                    end else if (scl_fall) begin
                        drv_q <= 1'b0;
                        if (load_tx) begin
                            st_q     <= ST_TX;
                            sh_q     <= tx_hold_q;
                            sda_oe_q <= !tx_hold_q[7];
                        end else begin
                            sda_oe_q <= 1'b0;
                            st_q     <= (st_q == ST_ADDR_ACK || ack_q) ? ST_RX : ST_WAIT;
                        end
                    end
                end
                ST_TX: begin
                    // drive next bit on each falling clock
                    if (scl_rise) begin
                        cnt_q <= cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == BYTE_BITS) begin
                        cnt_q    <= 4'h0;
                        sda_oe_q <= 1'b0;
                        st_q     <= ST_TX_ACK;
                    end else if (scl_fall && cnt_q != 4'h0) begin
                        sda_oe_q <= !sh_q[3'(LAST_BIT - cnt_q)];
                    end
                end
                ST_TX_ACK: begin
                    // master answers; go on only after an acknowledge
                    if (scl_rise) begin
                        drv_q <= 1'b1;
                    end else if (load_tx) begin
                        drv_q    <= 1'b0;
                        st_q     <= ST_TX;
                        sh_q     <= tx_hold_q;
                        sda_oe_q <= !tx_hold_q[7];
                    end else if (scl_fall && drv_q) begin
                        drv_q <= 1'b0;
                        st_q  <= ST_WAIT;
                    end
                end
                ST_IDLE, ST_WAIT: begin
                    sda_oe_q <= 1'b0;
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bus status: ack result, ack valid, restart, busy, transaction tracking
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            ack_q       <= 1'b0;
            ack_valid_q <= 1'b0;
            restart_q   <= 1'b0;
            busy_q      <= 1'b0;
            addressed_q <= 1'b0;
            rd_q        <= 1'b0;
            rx_data_q   <= 8'h00;
        end else begin
            if (start_w) begin
                busy_q <= 1'b1;
            end else if (stop_w) begin
                busy_q <= 1'b0;
            end
            if (set_spr) begin
                restart_q <= start_w;
            end
            if (start_w || stop_w) begin
                ack_valid_q <= 1'b0;
                addressed_q <= 1'b0;
            end else if (load_tx) begin
                ack_valid_q <= 1'b0;
            end else if (st_q == ST_TX_ACK && scl_rise) begin
                ack_q       <= !sda_s;
                ack_valid_q <= 1'b1;
            end else if (set_rx) begin
                ack_q     <= !ctl_q[CT_NAK];
                rx_data_q <= {sh_q[6:0], sda_s};
            end
            if (set_hit) begin
                addressed_q <= 1'b1;
                rd_q        <= sda_s;
                ack_q       <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sticky status flags: set wins over any clear
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            addr_hit_q <= 1'b0;
            rxf_q <= 1'b0;
            spr_q <= 1'b0;
            txe_q <= 1'b1;
        end else begin
            if (set_hit) begin
                addr_hit_q <= 1'b1;
            end else if (rd_stat || (wr_w && WB_ADR_I == OFS_ISTAT && WB_DAT_I[IS_HIT])) begin
                addr_hit_q <= 1'b0;
            end
            if (set_rx) begin
                rxf_q <= 1'b1;
            end else if (rd_data || (wr_w && WB_ADR_I == OFS_ISTAT && WB_DAT_I[IS_RXF])) begin
                rxf_q <= 1'b0;
            end
            if (set_spr) begin
                spr_q <= 1'b1;
            end else if (rd_stat || (wr_w && WB_ADR_I == OFS_ISTAT && WB_DAT_I[IS_SPR])) begin
                spr_q <= 1'b0;
            end
            if (load_tx) begin
                txe_q <= 1'b1;
            end else if (wr_w && WB_ADR_I == OFS_DATA) begin
                txe_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // wishbone register file, one-cycle ack, interrupt output
    logic [7:0] istat_w, bstat_w, rdat_w;
    assign istat_w = {txe_q, rxf_q, addr_hit_q, 1'b0, rd_q, 1'b0, spr_q, 1'b0};
    assign bstat_w = {ack_valid_q, ack_q, st_q == ST_ADDR,
                      st_q == ST_RX || st_q == ST_TX, 1'b0, restart_q, !SCL_OE_O, busy_q};

    // read multiplexer; unmapped offsets read zero
    always_comb begin
        case (WB_ADR_I)
            OFS_DATA:  rdat_w = rx_data_q;
            OFS_ISTAT: rdat_w = istat_w;
            OFS_IMASK: rdat_w = imask_q;
            OFS_CTL:   rdat_w = ctl_q;
            OFS_MODE:  rdat_w = {6'h00, mode_q};
            OFS_OADDR: rdat_w = {1'b0, own_addr_q};
            OFS_BSTAT: rdat_w = bstat_w;
            default:   rdat_w = 8'h00;
        endcase
    end

    // writable registers
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            ctl_q      <= RST_CTL;
            mode_q     <= MODE_MS;
            own_addr_q <= RST_OADDR;
            imask_q    <= RST_IMASK;
            tx_hold_q  <= 8'h00;
        end else if (wr_w) begin
            case (WB_ADR_I)
                OFS_DATA:  tx_hold_q  <= WB_DAT_I[7:0];
                OFS_IMASK: imask_q    <= WB_DAT_I[7:0];
                OFS_CTL:   ctl_q      <= {5'h00, WB_DAT_I[2:0]};
                OFS_MODE:  mode_q     <= WB_DAT_I[1:0];
                OFS_OADDR: own_addr_q <= WB_DAT_I[6:0];
                default:   ;
            endcase
        end
    end

    // bus answer, interrupt and pin drive flops
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
            IRQ_O    <= 1'b0;
            SCL_O    <= 1'b0;
            SCL_OE_O <= 1'b0;
            SDA_O    <= 1'b0;
            SDA_OE_O <= 1'b0;
        end else if (CE_I) begin
            WB_ACK_O <= WB_CYC_I && WB_STB_I && !WB_ACK_O;
            if (acc) begin
                WB_DAT_O <= {24'h00_0000, rdat_w};
            end
            IRQ_O    <= |(istat_w & imask_q & 8'hE2);
            SDA_OE_O <= sda_oe_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (!rst_n);

    property p_hit;
        set_hit && !sda_s |=> addr_hit_q && !rd_q;
    endproperty
    a_hit: assert property (p_hit) else $error("address match not flagged");
    property p_addr_ack;
        st_q == ST_ADDR_ACK && scl_fall && !drv_q |=> ##1 SDA_OE_O;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("address not acked");
    property p_hit_clr;
        rd_stat && !set_hit |=> !addr_hit_q;
    endproperty
    a_hit_clr: assert property (p_hit_clr) else $error("match flag kept");
    property p_rx_ack;
        st_q == ST_RX_ACK && scl_fall && !drv_q |=> ##1 SDA_OE_O == !$past(ctl_q[CT_NAK], 2);
    endproperty
    a_rx_ack: assert property (p_rx_ack) else $error("wrong rx answer");
    property p_rxf;
        set_rx |=> rxf_q && rx_data_q == $past({sh_q[6:0], sda_s});
    endproperty
    a_rxf: assert property (p_rxf) else $error("rx byte not flagged");
    property p_rxf_clr;
        rd_data && !set_rx |=> !rxf_q;
    endproperty
    a_rxf_clr: assert property (p_rxf_clr) else $error("rx flag kept");
    property p_spr;
        (start_w || stop_w) && addressed_q |=> spr_q && restart_q == $past(start_w);
    endproperty
    a_spr: assert property (p_spr) else $error("stop flag wrong");
    property p_spr_clr;
        rd_stat && !set_spr |=> !spr_q;
    endproperty
    a_spr_clr: assert property (p_spr_clr) else $error("stop flag kept");
    property p_ack_valid;
        start_w || stop_w |=> !ack_valid_q;
    endproperty
    a_ack_valid: assert property (p_ack_valid) else $error("ack valid kept");
    // busy rises with a start and stays up until a stop is seen
    property p_busy;
        start_w || (busy_q && !stop_w) |=> busy_q;
    endproperty
    a_busy: assert property (p_busy) else $error("busy dropped");
    property p_irq;
        addr_hit_q && imask_q[IS_HIT] && CE_I |=> IRQ_O;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");

    c_hit: cover property (set_hit);
    c_rx:  cover property (set_rx ##[1:200] rd_data);
    c_tx:  cover property (st_q == ST_TX_ACK && scl_rise && !sda_s);
    c_spr: cover property (set_spr && start_w);
endmodule

// *** src/isc_sync.sv ***
// two-flop synchroniser for a group of bits arriving from outside the clock domain
`timescale 1ns/1ps
module isc_sync
    import isc_pkg::*;
#(
    parameter int WIDTH = 2
) (
    // clock, reset, enable
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             ce_i,
    // asynchronous in, synchronised out
    input  wire logic [WIDTH-1:0] async_i,
    input  wire logic [WIDTH-1:0] init_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;  // first stage, read only by the second

    // one pair of flops per bit; bus lines idle high so both stages reset to one
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                meta_q[i] <= 1'b1;
                sync_o[i] <= 1'b1;
            end else if (ce_i) begin
                meta_q[i] <= async_i[i];
                sync_o[i] <= meta_q[i];
            end
        end
    end

    // init_i is unused by the logic; kept for a common port shape
    logic unused_w;
    assign unused_w = ^init_i;
endmodule
